// ---- rtl/ppu_pkg.sv ----
// Notes on behaviour
// - one-byte config: size, commissioning off, rpa select, hide key, three update flags
// - staged values apply only on a button press then release, flags evaluated then
// - source address stage replaces low 32 bits, upper 16 fixed device-type code
// - address flag set on actuation: copy stage to low address, clear flag
// - sixteen-byte key stage holds unique key and accepts user replacement
// - forbidden staged key patterns, all ones included, block the key update
// - key flag set on actuation: copy staged key to private key, clear flag
// - private flag on key update hides key from nfc, reports zeros in commissioning
// - key update with private flag clear restores public readable key mode
// - key read back only via stage; overwritten stage loses old key
// - eight-byte publicly readable product identifier
// - two-byte maker code inserted into each telegram, factory default replaceable
// - staged maker code of zero leaves stored maker code unchanged
// - maker flag on actuation: copy nonzero product_identifier and maker code, clear flag
// - protected accesses refused until unlocked with the correct 32-bit access code
// - payload size field: 00 none, 01 one, 10 two, 11 four bytes
package ppu_pkg;
  // page indices of the configuration memory, four bytes per page
  localparam logic [7:0] PG_PRODUCT_LO = 8'h06;
  localparam logic [7:0] PG_PRODUCT_HI = 8'h07;
  localparam logic [7:0] PG_MAKER = 8'h08;
  localparam logic [7:0] PG_SRC_ADDR = 8'h0C;
  localparam logic [7:0] PG_CONFIG = 8'h0E;
  localparam logic [7:0] PG_PROD_STAGE_LO = 8'h10;
  localparam logic [7:0] PG_PROD_STAGE_HI = 8'h11;
  localparam logic [7:0] PG_ADDR_STAGE = 8'h12;
  localparam logic [7:0] PG_MAKER_STAGE = 8'h13;
  localparam logic [7:0] PG_KEY_STAGE0 = 8'h14;
  localparam logic [7:0] PG_KEY_STAGE3 = 8'h17;
  localparam logic [7:0] PG_PROTECT_FIRST = 8'h0E;
  localparam logic [7:0] PG_ACCESS_CODE = 8'hE5;
  // config field positions
  localparam int CFG_SIZE_HI = 7;
  localparam int CFG_SIZE_LO = 6;
  localparam int CFG_COMMISSION_TX_OFF = 5;
  localparam int CFG_RESOLVABLE_ADDR_SEL = 4;
  localparam int CFG_PRIVATE_KEY = 3;
  localparam int CFG_KEY_UPDATE_REQ = 2;
  localparam int CFG_MAKER_UPDATE_REQ = 1;
  localparam int CFG_ADDR_UPDATE_REQ = 0;
  // reset values
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [63:0] PRODUCT_RESET = 64'h0000000000000000;
  localparam logic [127:0] KEY_ALL_ONES = {128{1'b1}};
  localparam logic [127:0] KEY_ALL_ZERO = 128'h0;
  localparam logic [15:0] MAKER_ZERO = 16'h0000;
  localparam logic [1:0] SYNC_STAGES = 2'h2;

  typedef struct packed {
    logic [1:0] payloadSize;
    logic commissionTxOff;
    logic resolvableAddrSel;
    logic privateKey;
    logic keyUpdateReq;
    logic makerUpdateReq;
    logic addrUpdateReq;
  } ppu_cfg_t;

  typedef struct packed {
    logic [47:0] sourceAddr;
    logic [63:0] productId;
    logic [15:0] makerCode;
    logic [127:0] txKey;
    logic [2:0] payloadBytes;
    logic commissionTxOff;
    logic resolvableAddrSel;
  } ppu_live_t;
endpackage

// ---- rtl/ppu_actuation.sv ----
`timescale 1ns/1ps
`default_nettype none
// one-cycle pulse on release after a seen press
module ppu_actuation
(
  input wire logic mclk,
  input wire logic rstN,
  input wire logic buttonDown,
  output logic actuate
);
  logic pressed_ff;
  logic prev_ff;

  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      prev_ff <= 1'b0;
      pressed_ff <= 1'b0;
    end
    else
    begin
      prev_ff <= buttonDown;
      if (buttonDown && !prev_ff)
        pressed_ff <= 1'b1;
      else if (!buttonDown && prev_ff)
        pressed_ff <= 1'b0;
    end
  end

  // a release without a recorded press does nothing
  assign actuate = !buttonDown && prev_ff && pressed_ff;
endmodule
`default_nettype wire

// ---- rtl/ppu_param_update.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppu_param_update
#(
  parameter logic [15:0] DEVICE_TYPE = 16'h1234, // arbitrary value
  parameter logic [15:0] MAKER_DEFAULT = 16'h00A5, // arbitrary value
  parameter logic [31:0] ADDR_DEFAULT = 32'h00000001,
  parameter logic [127:0] KEY_DEFAULT = 128'h0123456789ABCDEF0011223344556677,
  parameter logic [31:0] ACCESS_CODE_DEFAULT = 32'h00000000,
  parameter int KEY_FORBID_N = 2,
  parameter logic [KEY_FORBID_N*128-1:0] KEY_FORBID = {ppu_pkg::KEY_ALL_ONES,
                                                        ppu_pkg::KEY_ALL_ZERO}
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic buttonDown,
  input wire logic nfcWrite,
  input wire logic nfcRead,
  input wire logic [7:0] nfcPage,
  input wire logic [31:0] nfcWdata,
  output logic [31:0] nfcRdata,
  output logic nfcRvalid,
  output logic nfcRefused,
  output logic unlocked,
  output ppu_pkg::ppu_live_t live,
  output logic updateDone
);
  initial
  begin
    if (KEY_FORBID_N < 1)
      $error("KEY_FORBID_N must be at least one");
  end

  logic [1:0] rstSync_ff;
  logic rstN;
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      rstSync_ff <= 2'b00;
    else
      rstSync_ff <= {rstSync_ff[0], 1'b1};
  end
  assign rstN = rstSync_ff[1];

  ppu_pkg::ppu_cfg_t cfg_ff;
  logic [31:0] addrStage_ff;
  logic [127:0] keyStage_ff;
  logic [63:0] prodStage_ff;
  logic [15:0] makerStage_ff;
  logic [31:0] addrLow_ff;
  logic [63:0] product_ff;
  logic [15:0] maker_ff;
  logic [127:0] key_ff;
  logic keyPrivate_ff;
  logic [31:0] accessCode_ff;
  logic unlocked_ff;
  logic actuate;
  logic keyForbidden;
  logic protectedPage;
  logic accessOk;

  ppu_actuation u_act
  (
    .mclk(mclk),
    .rstN(rstN),
    .buttonDown(buttonDown),
    .actuate(actuate)
  );

  // forbidden key patterns compared in parallel
  logic [KEY_FORBID_N-1:0] forbidHit;
  genvar g;
  generate
    for (g = 0; g < KEY_FORBID_N; g++)
    begin : g_forbid
      assign forbidHit[g] = (keyStage_ff == KEY_FORBID[g*128 +: 128]);
    end
  endgenerate
  assign keyForbidden = |forbidHit;

  // the code page stays open, else a locked tool could never present the code
  assign protectedPage = nfcPage >= ppu_pkg::PG_PROTECT_FIRST && nfcPage != ppu_pkg::PG_ACCESS_CODE;
  assign accessOk = !protectedPage || unlocked_ff;

  // while locked the stored code opens the area; once open a write sets a new code
  // limitation: the code lives in flops, so a reset brings back the default
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      unlocked_ff <= 1'b0;
      accessCode_ff <= ACCESS_CODE_DEFAULT;
    end
    else if (nfcWrite && nfcPage == ppu_pkg::PG_ACCESS_CODE)
    begin
      if (!unlocked_ff)
        unlocked_ff <= (nfcWdata == accessCode_ff);
      else
        accessCode_ff <= nfcWdata;
    end
  end

  // config register: nfc writes, actuation clears serviced flags (actuation wins, a same-cycle write is dropped)
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      cfg_ff <= ppu_pkg::CONFIG_RESET;
    else if (actuate)
    begin
      cfg_ff.addrUpdateReq <= 1'b0;
      cfg_ff.makerUpdateReq <= 1'b0;
      // rejected key leaves its flag set, as the update did not succeed
      if (!keyForbidden)
        cfg_ff.keyUpdateReq <= 1'b0;
    end
    else if (nfcWrite && accessOk && nfcPage == ppu_pkg::PG_CONFIG)
      cfg_ff <= nfcWdata[31:24];
  end

  // staging registers
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      addrStage_ff <= ADDR_DEFAULT;
      keyStage_ff <= KEY_DEFAULT;
      prodStage_ff <= ppu_pkg::PRODUCT_RESET;
      makerStage_ff <= ppu_pkg::MAKER_ZERO;
    end
    else if (nfcWrite && accessOk)
    begin
      case (nfcPage)
        ppu_pkg::PG_ADDR_STAGE: addrStage_ff <= nfcWdata;
        ppu_pkg::PG_PROD_STAGE_LO: prodStage_ff[63:32] <= nfcWdata;
        ppu_pkg::PG_PROD_STAGE_HI: prodStage_ff[31:0] <= nfcWdata;
        ppu_pkg::PG_MAKER_STAGE: makerStage_ff <= nfcWdata[31:16];
        default:
        begin
          if (nfcPage >= ppu_pkg::PG_KEY_STAGE0 && nfcPage <= ppu_pkg::PG_KEY_STAGE3)
            keyStage_ff[(3 - (nfcPage[1:0])) * 32 +: 32] <= nfcWdata;
        end
      endcase
    end
  end

  // live parameters, each update independent
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      addrLow_ff <= ADDR_DEFAULT;
      product_ff <= ppu_pkg::PRODUCT_RESET;
      maker_ff <= MAKER_DEFAULT;
      key_ff <= KEY_DEFAULT;
      keyPrivate_ff <= 1'b0;
    end
    else if (actuate)
    begin
      if (cfg_ff.addrUpdateReq)
        addrLow_ff <= addrStage_ff;
      if (cfg_ff.keyUpdateReq && !keyForbidden)
      begin
        key_ff <= keyStage_ff;
        keyPrivate_ff <= cfg_ff.privateKey;
      end
      if (cfg_ff.makerUpdateReq)
      begin
        if (prodStage_ff != ppu_pkg::PRODUCT_RESET)
          product_ff <= prodStage_ff;
        if (makerStage_ff != ppu_pkg::MAKER_ZERO)
          maker_ff <= makerStage_ff;
      end
    end
  end

  // nfc read port; key stage hidden in private mode
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      nfcRdata <= 32'h00000000;
      nfcRvalid <= 1'b0;
      nfcRefused <= 1'b0;
    end
    else
    begin
      nfcRvalid <= nfcRead && accessOk;
      nfcRefused <= (nfcRead || nfcWrite) && !accessOk;
      if (nfcRead && accessOk)
      begin
        case (nfcPage)
          ppu_pkg::PG_PRODUCT_LO: nfcRdata <= product_ff[63:32];
          ppu_pkg::PG_PRODUCT_HI: nfcRdata <= product_ff[31:0];
          ppu_pkg::PG_MAKER: nfcRdata <= {16'h0000, maker_ff};
          ppu_pkg::PG_SRC_ADDR: nfcRdata <= addrLow_ff;
          ppu_pkg::PG_CONFIG: nfcRdata <= {cfg_ff, 24'h000000};
          ppu_pkg::PG_ADDR_STAGE: nfcRdata <= addrStage_ff;
          ppu_pkg::PG_PROD_STAGE_LO: nfcRdata <= prodStage_ff[63:32];
          ppu_pkg::PG_PROD_STAGE_HI: nfcRdata <= prodStage_ff[31:0];
          ppu_pkg::PG_MAKER_STAGE: nfcRdata <= {makerStage_ff, 16'h0000};
          default:
          begin
            if (nfcPage >= ppu_pkg::PG_KEY_STAGE0 && nfcPage <= ppu_pkg::PG_KEY_STAGE3)
              nfcRdata <= keyPrivate_ff ? 32'h00000000 :
                          keyStage_ff[(3 - (nfcPage[1:0])) * 32 +: 32];
            else
              nfcRdata <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // live outputs registered once more so they come from flip-flops
  always_ff @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      live <= '0;
      updateDone <= 1'b0;
      unlocked <= 1'b0;
    end
    else
    begin
      live.sourceAddr <= {DEVICE_TYPE, addrLow_ff};
      live.productId <= product_ff;
      live.makerCode <= maker_ff;
      live.txKey <= keyPrivate_ff ? ppu_pkg::KEY_ALL_ZERO : key_ff;
      case (cfg_ff.payloadSize)
        2'b00: live.payloadBytes <= 3'h0;
        2'b01: live.payloadBytes <= 3'h1;
        2'b10: live.payloadBytes <= 3'h2;
        default: live.payloadBytes <= 3'h4;
      endcase
      live.commissionTxOff <= cfg_ff.commissionTxOff;
      live.resolvableAddrSel <= cfg_ff.resolvableAddrSel;
      updateDone <= actuate;
      unlocked <= unlocked_ff;
    end
  end

  // live path checks
  a_addr_copy: assert property (@(posedge mclk) disable iff (!rstN)
    actuate && cfg_ff.addrUpdateReq |=> addrLow_ff == $past(addrStage_ff))
    else $error("address not copied");
  a_addr_clear: assert property (@(posedge mclk) disable iff (!rstN)
    actuate |=> !cfg_ff.addrUpdateReq && !cfg_ff.makerUpdateReq)
    else $error("update flag not cleared");
  a_key_forbid: assert property (@(posedge mclk) disable iff (!rstN)
    actuate && keyForbidden |=> $stable(key_ff))
    else $error("forbidden key applied");
  a_key_flag_keep: assert property (@(posedge mclk) disable iff (!rstN)
    actuate && keyForbidden && cfg_ff.keyUpdateReq |=> cfg_ff.keyUpdateReq)
    else $error("rejected key flag cleared");
  a_key_copy: assert property (@(posedge mclk) disable iff (!rstN)
    actuate && cfg_ff.keyUpdateReq && !keyForbidden |=> key_ff == $past(keyStage_ff)
      && !cfg_ff.keyUpdateReq)
    else $error("key not copied");
  a_key_private: assert property (@(posedge mclk) disable iff (!rstN)
    actuate && cfg_ff.keyUpdateReq && !keyForbidden |=> keyPrivate_ff == $past(cfg_ff.privateKey))
    else $error("key mode not taken");
  a_maker_zero: assert property (@(posedge mclk) disable iff (!rstN)
    actuate && makerStage_ff == 16'h0000 |=> $stable(maker_ff))
    else $error("zero maker code applied");
  a_maker_copy: assert property (@(posedge mclk) disable iff (!rstN)
    actuate && cfg_ff.makerUpdateReq && makerStage_ff != 16'h0000 |=> maker_ff == $past(makerStage_ff))
    else $error("maker code not copied");
  a_prod_copy: assert property (@(posedge mclk) disable iff (!rstN)
    actuate && cfg_ff.makerUpdateReq && prodStage_ff != 64'h0 |=> product_ff == $past(prodStage_ff))
    else $error("product_identifier not copied");
  a_no_actuate: assert property (@(posedge mclk) disable iff (!rstN)
    !actuate |=> $stable(addrLow_ff) && $stable(maker_ff) && $stable(product_ff))
    else $error("live value changed without actuation");
  a_update_done: assert property (@(posedge mclk) disable iff (!rstN)
    actuate |=> updateDone)
    else $error("actuation not reported");
  a_size_decode: assert property (@(posedge mclk) disable iff (!rstN)
    1'b1 |=> live.payloadBytes == (($past(cfg_ff.payloadSize) == 2'h3) ? 3'h4 :
      {1'h0, $past(cfg_ff.payloadSize)}))
    else $error("payload size decoded wrong");
  a_private_hide: assert property (@(posedge mclk) disable iff (!rstN)
    keyPrivate_ff |=> live.txKey == 128'h0)
    else $error("private key exposed");
  a_addr_upper: assert property (@(posedge mclk) disable iff (!rstN)
    1'b1 |=> live.sourceAddr[47:32] == DEVICE_TYPE)
    else $error("device type altered");

  // nfc port checks
  a_lock_refuse: assert property (@(posedge mclk) disable iff (!rstN)
    nfcWrite && !accessOk && !actuate |=> $stable(cfg_ff) && $stable(addrStage_ff)
      && $stable(keyStage_ff) && $stable(prodStage_ff) && $stable(makerStage_ff) && nfcRefused)
    else $error("locked write accepted");
  a_unlock_code: assert property (@(posedge mclk) disable iff (!rstN)
    nfcWrite && !unlocked_ff && nfcPage == ppu_pkg::PG_ACCESS_CODE |=>
      unlocked_ff == ($past(nfcWdata) == ACCESS_CODE_DEFAULT))
    else $error("unlock decision wrong");
  a_read_valid: assert property (@(posedge mclk) disable iff (!rstN)
    nfcRead && accessOk |=> nfcRvalid && !nfcRefused)
    else $error("accepted read not answered");
  a_read_private: assert property (@(posedge mclk) disable iff (!rstN)
    nfcRead && accessOk && keyPrivate_ff && nfcPage >= ppu_pkg::PG_KEY_STAGE0
      && nfcPage <= ppu_pkg::PG_KEY_STAGE3 |=> nfcRdata == 32'h00000000)
    else $error("private key readable");
endmodule
`default_nettype wire

// ---- sim/ppu_tool_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// config tool and button; a released data bus shows the inverse of its last value
module ppu_tool_model
(
  input wire logic mclk,
  input wire logic [31:0] nfcRdata,
  input wire logic nfcRvalid,
  input wire logic nfcRefused,
  input wire logic updateDone,
  output logic buttonDown,
  output logic nfcWrite,
  output logic nfcRead,
  output logic [7:0] nfcPage,
  output logic [31:0] nfcWdata
);
  logic refSeen;
  initial
  begin
    buttonDown = 1'h0;
    nfcWrite = 1'h0;
    nfcRead = 1'h0;
    nfcPage = 8'h00;
    nfcWdata = 32'h0;
    refSeen = 1'h0;
  end
  task automatic wr(input logic [7:0] p, input logic [31:0] d);
    @(posedge mclk);
    nfcWrite <= 1'h1;
    nfcPage <= p;
    nfcWdata <= d;
    @(posedge mclk);
    nfcWrite <= 1'h0;
    nfcWdata <= ~d;
    @(negedge mclk);
    refSeen = nfcRefused;
  endtask
  task automatic rd(input logic [7:0] p, output logic [33:0] r);
    @(posedge mclk);
    nfcRead <= 1'h1;
    nfcPage <= p;
    @(posedge mclk);
    nfcRead <= 1'h0;
    @(negedge mclk);
    r = {nfcRvalid, nfcRefused, nfcRdata};
  endtask
  // stages and flags are always written before the press
  task automatic press(output logic done);
    @(posedge mclk);
    buttonDown <= 1'h1;
    repeat (3) @(posedge mclk);
    buttonDown <= 1'h0;
    done = 1'h0;
    repeat (6)
    begin
      @(negedge mclk);
      done = done | (updateDone === 1'h1);
    end
  endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) \
  begin \
    total_checks++; \
    if ((a) !== (b)) \
    begin \
      fail_count++; \
      $display("CHECK FAILED t=%0t %s", $time, m); \
    end \
  end
module testbench;
  localparam logic [15:0] DEV_T = 16'h3C5A; // arbitrary value
  localparam logic [15:0] MK_DEF = 16'h7E11; // arbitrary value
  localparam logic [31:0] AD_DEF = 32'h1A2B3C4D;
  localparam logic [127:0] KEY_DEF = 128'h00112233445566778899AABBCCDDEEF0;
  logic mclk, reset_n, buttonDown, nfcWrite, nfcRead, nfcRvalid, nfcRefused;
  logic unlocked, updateDone, done, expPriv, keyBad;
  logic [7:0] nfcPage, expCfg, cfg;
  logic [31:0] nfcWdata, nfcRdata, expAddr, sa;
  logic [63:0] expProd, pr;
  logic [15:0] expMaker, mk;
  logic [127:0] expKey, key;
  logic [33:0] r;
  ppu_pkg::ppu_live_t live;
  int fail_count = 0;
  int total_checks = 0;
  ppu_param_update #(.DEVICE_TYPE(DEV_T), .MAKER_DEFAULT(MK_DEF), .ADDR_DEFAULT(AD_DEF),
    .KEY_DEFAULT(KEY_DEF)) ppu_param_update_i (.mclk(mclk), .reset_n(reset_n),
    .buttonDown(buttonDown), .nfcWrite(nfcWrite), .nfcRead(nfcRead), .nfcPage(nfcPage),
    .nfcWdata(nfcWdata), .nfcRdata(nfcRdata), .nfcRvalid(nfcRvalid),
    .nfcRefused(nfcRefused), .unlocked(unlocked), .live(live), .updateDone(updateDone));
  ppu_tool_model ppu_tool_model_i (.mclk(mclk), .nfcRdata(nfcRdata), .nfcRvalid(nfcRvalid),
    .nfcRefused(nfcRefused), .updateDone(updateDone), .buttonDown(buttonDown),
    .nfcWrite(nfcWrite), .nfcRead(nfcRead), .nfcPage(nfcPage), .nfcWdata(nfcWdata));
  initial
  begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chkLive();
    `CHK(live.sourceAddr, {DEV_T, expAddr}, "address")
    `CHK(live.productId, expProd, "product")
    `CHK(live.makerCode, expMaker, "maker")
    `CHK(live.txKey, expPriv ? 128'h0 : expKey, "key")
    `CHK(live.payloadBytes, (expCfg[7:6] == 2'h3) ? 3'h4 : {1'h0, expCfg[7:6]}, "size")
    `CHK(live.commissionTxOff, expCfg[5], "txoff")
    `CHK(live.resolvableAddrSel, expCfg[4], "rpa")
  endtask
  initial
  begin
    #3000000;
    fail_count++;
    summarize();
  end
  initial
  begin
    void'($urandom(90));
    reset_n = 1'h0;
    expAddr = AD_DEF;
    expProd = ppu_pkg::PRODUCT_RESET;
    expMaker = MK_DEF;
    expKey = KEY_DEF;
    expPriv = 1'h0;
    expCfg = ppu_pkg::CONFIG_RESET;
    repeat (12) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (8) @(negedge mclk);
    chkLive();
    ppu_tool_model_i.rd(ppu_pkg::PG_SRC_ADDR, r);
    `CHK(r[33], 1'h1, "public read")
    `CHK(r[31:0], AD_DEF, "address read")
    // locked: a config write with every flag set must not land
    ppu_tool_model_i.wr(ppu_pkg::PG_CONFIG, 32'hFF000000);
    `CHK(ppu_tool_model_i.refSeen, 1'h1, "locked write")
    ppu_tool_model_i.wr(ppu_pkg::PG_ACCESS_CODE, 32'h00000001);
    `CHK(ppu_tool_model_i.refSeen, 1'h0, "code page open")
    @(negedge mclk);
    `CHK(unlocked, 1'h0, "wrong code")
    ppu_tool_model_i.wr(ppu_pkg::PG_ACCESS_CODE, 32'h00000000);
    @(negedge mclk);
    `CHK(unlocked, 1'h1, "unlock")
    ppu_tool_model_i.rd(ppu_pkg::PG_CONFIG, r);
    `CHK(r[31:24], expCfg, "refused config")
    $display("test lock done");
    for (int i = 0; i < 6; i++)
    begin
      sa = $urandom;
      pr = (i == 2) ? 64'h0 : {$urandom, $urandom};
      mk = (i == 1) ? 16'h0000 : 16'($urandom);
      key = {$urandom, $urandom, $urandom, $urandom};
      if (i == 1)
        key = ppu_pkg::KEY_ALL_ONES;
      if (i == 3)
        key = ppu_pkg::KEY_ALL_ZERO;
      cfg = {2'(i), 2'($urandom), i == 2, (i == 4) ? 3'h2 : 3'h7};
      ppu_tool_model_i.wr(ppu_pkg::PG_ADDR_STAGE, sa);
      ppu_tool_model_i.wr(ppu_pkg::PG_PROD_STAGE_LO, pr[63:32]);
      ppu_tool_model_i.wr(ppu_pkg::PG_PROD_STAGE_HI, pr[31:0]);
      ppu_tool_model_i.wr(ppu_pkg::PG_MAKER_STAGE, {mk, 16'h0000});
      for (int j = 0; j < 4; j++)
        ppu_tool_model_i.wr(ppu_pkg::PG_KEY_STAGE0 + 8'(j), key[127-32*j -: 32]);
      ppu_tool_model_i.wr(ppu_pkg::PG_CONFIG, {cfg, 24'h0});
      `CHK(live.sourceAddr, {DEV_T, expAddr}, "early update")
      ppu_tool_model_i.press(done);
      `CHK(done, 1'h1, "no update")
      keyBad = key == ppu_pkg::KEY_ALL_ONES || key == ppu_pkg::KEY_ALL_ZERO;
      expCfg = cfg;
      if (cfg[0])
        expAddr = sa;
      if (cfg[2] && !keyBad)
      begin
        expKey = key;
        expPriv = cfg[3];
      end
      if (cfg[1] && pr != 64'h0)
        expProd = pr;
      if (cfg[1] && mk != 16'h0000)
        expMaker = mk;
      expCfg[0] = 1'h0;
      expCfg[1] = 1'h0;
      expCfg[2] = cfg[2] & keyBad;
      repeat (2) @(negedge mclk);
      chkLive();
      ppu_tool_model_i.rd(ppu_pkg::PG_CONFIG, r);
      `CHK(r[31:24], expCfg, "flags")
      ppu_tool_model_i.rd(ppu_pkg::PG_SRC_ADDR, r);
      `CHK(r[31:0], expAddr, "address read")
      ppu_tool_model_i.rd(ppu_pkg::PG_KEY_STAGE0, r);
      `CHK(r[31:0], expPriv ? 32'h00000000 : key[127:96], "key read")
      ppu_tool_model_i.rd(ppu_pkg::PG_PRODUCT_LO, r);
      `CHK(r[31:0], expProd[63:32], "product read")
      $display("test %0d done", i);
    end
    summarize();
  end
endmodule
`default_nettype wire
